/* dor_top.sv */
// Digital output stage: output control word, per-bit manipulation, readback,
// routing mode with divided pulse sources and brake PWM, open-drain pins.
// Assumes all inputs are synchronous to clk_sys_i; step inputs are one-cycle
// pulses, one per increment.
//
// Overview of operation
// - Output n follows control word bit 15+n
// - Bits 0-15 special; bit 0 is brake
// - Pins only pull low or release
// - Each setting bit affects only its output
// - Polarity bit set inverts the output level
// - Override bit selects manual value, brake too
// - Readable word shows applied output pattern
// - Routing enable 1 selects routing mode
// - Routing mode ignores polarity and manual settings
// - Selector 0 PWM pin, 1-4 outputs
// - Pulse width fits 2 kHz / 500 Hz
// - Selector: high byte source, low byte gate
// - Selector bit 7 inverts the gating bit
// - Source 00 constant one, 01 zero
// - Sources 02-08 encoder pulses divided 1..64
// - Sources 09-0F position pulses divided 1..64
// - Source 10 brake PWM, 11 inverted
// - No encoder pulses with Hall feedback
// - Divider 1 gives one pulse per increment
// - PWM frequency in Hz, above 2000 rejected
// - Duty 2..100 percent, 100 stays on
`timescale 1ns/10ps
`default_nettype none

module dor_top
#(
    parameter int SWPWM_HOLD = dor_pkg::SWPWM_HOLD_CYC,
    parameter int OUT_HOLD = dor_pkg::OUT_HOLD_CYC
)
(
    input wire logic clk_sys_i,                        // System clock
    input wire logic srst_i,                           // Synchronous reset
    input wire logic [dor_pkg::ADDR_W-1:0] addr_i,     // Register byte address
    input wire logic [dor_pkg::DATA_W-1:0] wdata_i,    // Write data
    input wire logic wr_i,                             // Write strobe
    input wire logic rd_i,                             // Read strobe
    output logic [dor_pkg::DATA_W-1:0] rdata_o,        // Read data, one cycle later
    input wire logic enc_step_i,                       // Encoder increment pulse
    input wire logic pos_step_i,                       // Position increment pulse
    input wire logic hall_fb_i,                        // Hall sensors in use
    output logic [dor_pkg::NUM_OUT-1:0] out_o,         // Output pins, driven value
    output logic [dor_pkg::NUM_OUT-1:0] out_oe_n_o,    // Output pins, enable low
    output logic brake_o,                              // Brake pin, driven value
    output logic brake_oe_n_o,                         // Brake pin, enable low
    output logic swpwm_o,                              // Software PWM pin value
    output logic swpwm_oe_n_o                          // Software PWM pin enable low
);
    import dor_pkg::*;

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    if (SWPWM_HOLD < 1 || SWPWM_HOLD >= (1 << HOLD_W) || OUT_HOLD < 1 || OUT_HOLD >= (1 << HOLD_W))
    begin : g_bad_hold
        $error("dor_top: hold counts must lie in 1..65535");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] pol;
        logic [31:0] ovr;
        logic [31:0] mval;
        logic route_en;
        logic [NUM_CH-1:0][15:0] sel;
        logic [10:0] freq;
        logic [6:0] duty;
        logic [ACC_W-1:0] acc;
        logic [6:0] phase;
        logic [NUM_CH-1:0][5:0] enc_cnt;
        logic [NUM_CH-1:0][5:0] pos_cnt;
        logic [NUM_CH-1:0][HOLD_W-1:0] hold;
        logic [31:0] applied;
        logic [31:0] rdata;
        logic [NUM_OUT-1:0] out_oe_n;
        logic brake_oe_n;
        logic swpwm_oe_n;
    } dor_state_s;

    dor_state_s st_ff;
    dor_state_s nxt_st;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // True when a count with k low bits set completes a divide-by-2^k group
    function automatic logic dor_div_hit(input logic [5:0] cnt, input logic [7:0] k);
        logic [5:0] mask;
        mask = 6'(({6'h00, 1'b1} << k[2:0]) - 7'h01);
        return (cnt & mask) == mask;
    endfunction : dor_div_hit

    function automatic logic dor_in_range(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction : dor_in_range

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic [ACC_W-1:0] acc_sum;
    logic pwm_sig;
    logic enc_step;
    logic [NUM_CH-1:0] route_lvl;
    logic [31:0] manip_val;
    logic [31:0] manip_lvl;
    logic [NUM_OUT-1:0] out_lvl;
    logic brake_lvl;
    logic swpwm_lvl;
    logic [7:0] src;
    logic [7:0] chsel;
    logic fire;
    logic src_val;
    logic gate;

    always_comb
    begin
        nxt_st = st_ff;
        acc_sum = '0;
        pwm_sig = 1'b0;
        enc_step = 1'b0;
        route_lvl = '0;
        manip_val = '0;
        manip_lvl = '0;
        out_lvl = '0;
        brake_lvl = 1'b0;
        swpwm_lvl = 1'b0;
        src = '0;
        chsel = '0;
        fire = 1'b0;
        src_val = 1'b0;
        gate = 1'b0;

        // --------------------------------------------------------------
        // Register writes
        // --------------------------------------------------------------
        if (wr_i)
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                if (addr_i == 8'(OFS_SEL_BASE + 8'(4 * c)))
                begin
                    nxt_st.sel[c] = wdata_i[15:0];
                end
            end
            unique case (addr_i)
                OFS_CTRL_WORD: nxt_st.ctrl = wdata_i;
                OFS_POLARITY: nxt_st.pol = wdata_i;
                OFS_OVERRIDE: nxt_st.ovr = wdata_i;
                OFS_MAN_VALUE: nxt_st.mval = wdata_i;
                OFS_ROUTE_EN: nxt_st.route_en = wdata_i[0];
                OFS_PWM_FREQ:
                begin
                    if (wdata_i <= 32'(PWM_FREQ_MAX))
                    begin
                        nxt_st.freq = wdata_i[10:0];
                    end
                end
                OFS_PWM_DUTY:
                begin
                    if (wdata_i >= 32'(PWM_DUTY_MIN) && wdata_i <= 32'(PWM_DUTY_MAX))
                    begin
                        nxt_st.duty = wdata_i[6:0];
                    end
                end
                default: ;
            endcase
        end

        // --------------------------------------------------------------
        // Register reads, answered in the next cycle
        // --------------------------------------------------------------
        nxt_st.rdata = '0;
        if (rd_i)
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                if (addr_i == 8'(OFS_SEL_BASE + 8'(4 * c)))
                begin
                    nxt_st.rdata = {16'h0000, st_ff.sel[c]};
                end
            end
            unique case (addr_i)
                OFS_CTRL_WORD: nxt_st.rdata = st_ff.ctrl;
                OFS_POLARITY: nxt_st.rdata = st_ff.pol;
                OFS_OVERRIDE: nxt_st.rdata = st_ff.ovr;
                OFS_MAN_VALUE: nxt_st.rdata = st_ff.mval;
                OFS_APPLIED: nxt_st.rdata = st_ff.applied;
                OFS_ROUTE_EN: nxt_st.rdata = {31'h0000_0000, st_ff.route_en};
                OFS_PWM_FREQ: nxt_st.rdata = {21'h00_0000, st_ff.freq};
                OFS_PWM_DUTY: nxt_st.rdata = {25'h000_0000, st_ff.duty};
                default: ;
            endcase
        end

        // --------------------------------------------------------------
        // Brake PWM: phase steps 100 times per period
        // --------------------------------------------------------------
        acc_sum = ACC_W'(st_ff.acc + ACC_W'(st_ff.freq) * ACC_W'(PWM_DUTY_MAX));
        if (acc_sum >= ACC_W'(CLK_HZ))
        begin
            nxt_st.acc = ACC_W'(acc_sum - ACC_W'(CLK_HZ));
            nxt_st.phase = (st_ff.phase >= PWM_DUTY_MAX - 7'h01) ? 7'h00 : 7'(st_ff.phase + 7'h01);
        end
        else
        begin
            nxt_st.acc = acc_sum;
        end
        pwm_sig = (st_ff.duty >= PWM_DUTY_MAX) || (st_ff.phase < st_ff.duty);

        // --------------------------------------------------------------
        // Routing channels: 0 is the PWM pin, 1..4 the outputs
        // --------------------------------------------------------------
        enc_step = enc_step_i & ~hall_fb_i;
        for (int c = 0; c < NUM_CH; c++)
        begin
            src = st_ff.sel[c][15:8];
            chsel = st_ff.sel[c][7:0];
            fire = 1'b0;
            if (enc_step)
            begin
                nxt_st.enc_cnt[c] = 6'(st_ff.enc_cnt[c] + 6'h01);
                if (dor_in_range(src, SRC_ENC_FIRST, SRC_ENC_LAST))
                begin
                    fire = dor_div_hit(st_ff.enc_cnt[c], 8'(src - SRC_ENC_FIRST));
                end
            end
            if (pos_step_i)
            begin
                nxt_st.pos_cnt[c] = 6'(st_ff.pos_cnt[c] + 6'h01);
                if (dor_in_range(src, SRC_POS_FIRST, SRC_POS_LAST))
                begin
                    fire = dor_div_hit(st_ff.pos_cnt[c], 8'(src - SRC_POS_FIRST));
                end
            end
            // Stretch each pulse to half the fastest period the pin may carry
            if (fire)
            begin
                nxt_st.hold[c] = (c == 0) ? HOLD_W'(SWPWM_HOLD) : HOLD_W'(OUT_HOLD);
            end
            else if (st_ff.hold[c] != '0)
            begin
                nxt_st.hold[c] = HOLD_W'(st_ff.hold[c] - HOLD_W'(1));
            end

            if (src == SRC_CONST1)
            begin
                src_val = 1'b1;
            end
            else if (src == SRC_CONST0)
            begin
                src_val = 1'b0;
            end
            else if (dor_in_range(src, SRC_ENC_FIRST, SRC_POS_LAST))
            begin
                src_val = st_ff.hold[c] != '0;
            end
            else if (src == SRC_PWM)
            begin
                src_val = pwm_sig;
            end
            else if (src == SRC_PWM_INV)
            begin
                src_val = ~pwm_sig;
            end
            else
            begin
                src_val = 1'b0;
            end
            gate = st_ff.ctrl[chsel[4:0]] ^ chsel[SEL_INV_BIT];
            route_lvl[c] = gate & src_val;
        end

        // --------------------------------------------------------------
        // Normal mode manipulation, bit by bit
        // --------------------------------------------------------------
        manip_val = (st_ff.ovr & st_ff.mval) | (~st_ff.ovr & st_ff.ctrl);
        manip_lvl = manip_val ^ st_ff.pol;

        // --------------------------------------------------------------
        // Mode select and applied pattern
        // --------------------------------------------------------------
        if (st_ff.route_en)
        begin
            out_lvl = route_lvl[NUM_CH-1:1];
            swpwm_lvl = route_lvl[0];
            brake_lvl = st_ff.ctrl[BRAKE_BIT];
        end
        else
        begin
            out_lvl = manip_lvl[OUT1_BIT +: NUM_OUT];
            swpwm_lvl = 1'b0;
            brake_lvl = manip_lvl[BRAKE_BIT];
        end
        nxt_st.applied = '0;
        nxt_st.applied[OUT1_BIT +: NUM_OUT] = out_lvl;
        nxt_st.applied[BRAKE_BIT] = brake_lvl;

        // --------------------------------------------------------------
        // Open drain: high level releases, low level pulls down
        // --------------------------------------------------------------
        nxt_st.out_oe_n = out_lvl;
        nxt_st.swpwm_oe_n = swpwm_lvl;
        nxt_st.brake_oe_n = brake_lvl & pwm_sig;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            st_ff <= '0;
            st_ff.ctrl <= RST_WORD;
            st_ff.pol <= RST_WORD;
            st_ff.ovr <= RST_WORD;
            st_ff.mval <= RST_WORD;
            st_ff.sel <= {NUM_CH{RST_SEL}};
            st_ff.freq <= RST_PWM_FREQ;
            st_ff.duty <= RST_PWM_DUTY;
            st_ff.out_oe_n <= '0;
            st_ff.brake_oe_n <= 1'b0;
            st_ff.swpwm_oe_n <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs; driven values stay low for open drain
    // ------------------------------------------------------------------
    assign rdata_o = st_ff.rdata;
    assign out_o = st_ff.applied[OUT1_BIT +: NUM_OUT] & ~st_ff.applied[OUT1_BIT +: NUM_OUT];
    assign out_oe_n_o = st_ff.out_oe_n;
    assign brake_o = st_ff.applied[BRAKE_BIT] & ~st_ff.applied[BRAKE_BIT];
    assign brake_oe_n_o = st_ff.brake_oe_n;
    assign swpwm_o = st_ff.swpwm_oe_n & ~st_ff.swpwm_oe_n;
    assign swpwm_oe_n_o = st_ff.swpwm_oe_n;

endmodule : dor_top

`default_nettype wire

/* dor_pkg.sv */
// Package for the digital output routing block: register map, reset values,
// routing source codes and timing constants.
// Assumes a 50 MHz system clock and a plain byte-addressed register port.
package dor_pkg;

    // ------------------------------------------------------------------
    // Register bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL_WORD = 8'h00;
    localparam logic [7:0] OFS_UNUSED = 8'h04;
    localparam logic [7:0] OFS_POLARITY = 8'h08;
    localparam logic [7:0] OFS_OVERRIDE = 8'h0C;
    localparam logic [7:0] OFS_MAN_VALUE = 8'h10;
    localparam logic [7:0] OFS_APPLIED = 8'h14;
    localparam logic [7:0] OFS_ROUTE_EN = 8'h18;
    localparam logic [7:0] OFS_SEL_BASE = 8'h20;
    localparam logic [7:0] OFS_PWM_FREQ = 8'h34;
    localparam logic [7:0] OFS_PWM_DUTY = 8'h38;

    // ------------------------------------------------------------------
    // Bit layout of the output control word
    // ------------------------------------------------------------------
    localparam int BRAKE_BIT = 0;
    localparam int OUT1_BIT = 16;
    localparam int NUM_OUT = 4;
    localparam int NUM_CH = 5;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_SEL = 16'h0100;
    localparam logic [10:0] RST_PWM_FREQ = 11'h7D0;
    localparam logic [6:0] RST_PWM_DUTY = 7'h32;

    // ------------------------------------------------------------------
    // Routing selector fields and source codes
    // ------------------------------------------------------------------
    localparam int SEL_INV_BIT = 7;
    localparam logic [7:0] SRC_CONST1 = 8'h00;
    localparam logic [7:0] SRC_CONST0 = 8'h01;
    localparam logic [7:0] SRC_ENC_FIRST = 8'h02;
    localparam logic [7:0] SRC_ENC_LAST = 8'h08;
    localparam logic [7:0] SRC_POS_FIRST = 8'h09;
    localparam logic [7:0] SRC_POS_LAST = 8'h0F;
    localparam logic [7:0] SRC_PWM = 8'h10;
    localparam logic [7:0] SRC_PWM_INV = 8'h11;

    // ------------------------------------------------------------------
    // Brake PWM limits and timing
    // ------------------------------------------------------------------
    localparam logic [10:0] PWM_FREQ_MAX = 11'h7D0;
    localparam logic [6:0] PWM_DUTY_MIN = 7'h02;
    localparam logic [6:0] PWM_DUTY_MAX = 7'h64;
    localparam int CLK_HZ = 50_000_000;
    localparam int SWPWM_FMAX_HZ = 2000;
    localparam int OUT_FMAX_HZ = 500;
    localparam int SWPWM_HOLD_CYC = CLK_HZ / (2 * SWPWM_FMAX_HZ);
    localparam int OUT_HOLD_CYC = CLK_HZ / (2 * OUT_FMAX_HZ);
    localparam int HOLD_W = 16;
    localparam int ACC_W = 27;

endpackage : dor_pkg

/* dor_load.sv */
// Partner model: pull-up loads on the open-drain pins of dor_top.
// Expects value and enable-low vectors of equal width.
`timescale 1ns/10ps
`default_nettype none
module dor_load
#(
    parameter int W = 6
)
(
    input wire logic [W-1:0] drv_i, // Driven values
    input wire logic [W-1:0] oe_n_i, // Enables, low drives
    output logic [W-1:0] lvl_o // Pin levels
);
    // Released pins float up to the external supply
    assign lvl_o = oe_n_i | drv_i;
endmodule : dor_load
`default_nettype wire

/* dor_chk_properties.sv */
// Checker for dor_top: shadows settings written over the register port
// and ties pins and read data to them. Sees only the ports of dor_top.
`timescale 1ns/10ps
`default_nettype none
module dor_chk
#(
    parameter int SWPWM_HOLD = 4,
    parameter int OUT_HOLD = 8
)
(
    input wire logic clk_sys_i, // Clock
    input wire logic srst_i, // Reset
    input wire logic [dor_pkg::ADDR_W-1:0] addr_i, // Address
    input wire logic [dor_pkg::DATA_W-1:0] wdata_i, // Write data
    input wire logic wr_i, // Write
    input wire logic rd_i, // Read
    input wire logic [dor_pkg::DATA_W-1:0] rdata_o, // Read data
    input wire logic enc_step_i, // Encoder step
    input wire logic pos_step_i, // Position step
    input wire logic hall_fb_i, // Hall feedback
    input wire logic [dor_pkg::NUM_OUT-1:0] out_o, // Pin values
    input wire logic [dor_pkg::NUM_OUT-1:0] out_oe_n_o, // Pin enables
    input wire logic brake_o, // Brake value
    input wire logic brake_oe_n_o, // Brake enable
    input wire logic swpwm_o, // PWM pin value
    input wire logic swpwm_oe_n_o // PWM pin enable
);
    import dor_pkg::*;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (srst_i);
    logic [31:0] ctl, pol, ovr, mv, lvl, appl;
    logic rt;
    logic [15:0] sel [NUM_CH];
    logic [NUM_CH-1:0] gate;
    wire logic [NUM_CH-1:0] pin_n = {out_oe_n_o, swpwm_oe_n_o};
    // ----
    // Settings shadow
    // ----
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            ctl <= '0;
            pol <= '0;
            ovr <= '0;
            mv <= '0;
            rt <= 1'b0;
            for (int c = 0; c < NUM_CH; c++)
                sel[c] <= RST_SEL;
        end
        else if (wr_i)
        begin
            if (addr_i == OFS_CTRL_WORD) ctl <= wdata_i;
            if (addr_i == OFS_POLARITY) pol <= wdata_i;
            if (addr_i == OFS_OVERRIDE) ovr <= wdata_i;
            if (addr_i == OFS_MAN_VALUE) mv <= wdata_i;
            if (addr_i == OFS_ROUTE_EN) rt <= wdata_i[0];
            for (int c = 0; c < NUM_CH; c++)
                if (addr_i == OFS_SEL_BASE + 8'(4 * c)) sel[c] <= wdata_i[15:0];
        end
    end
    always_comb
    begin
        lvl = ((ovr & mv) | (~ovr & ctl)) ^ pol;
        appl = {12'h000, lvl[19:16], 15'h0000, lvl[0]};
        for (int c = 0; c < NUM_CH; c++)
            gate[c] = ctl[sel[c][4:0]] ^ sel[c][7];
    end
    // ----
    // Properties
    // ----
    sequence enc_arm_s;
        rt && sel[1][15:8] == SRC_ENC_FIRST && gate[1] && enc_step_i && !hall_fb_i;
    endsequence
    sequence enc_hold_s;
        ##2 out_oe_n_o[0] ##1 out_oe_n_o[0];
    endsequence
    sequence hall_s;
        (rt && sel[1][15:8] == SRC_ENC_FIRST && gate[1] && hall_fb_i) [*3];
    endsequence
    drive_low_a: assert property (out_o == '0 && !brake_o && !swpwm_o)
        else $error("pin driven high");
    rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == '0)
        else $error("read data outside read slot");
    unused_read_a: assert property (rd_i && addr_i == OFS_UNUSED |=> rdata_o == '0)
        else $error("unused entry not zero");
    normal_level_a: assert property (!rt |=> out_oe_n_o == $past(lvl[19:16]))
        else $error("output level wrong");
    brake_level_a: assert property (!(rt ? ctl[0] : lvl[0]) |=> !brake_oe_n_o)
        else $error("brake released while off");
    applied_read_a: assert property (rd_i && addr_i == OFS_APPLIED && !rt && !$past(wr_i)
        |=> rdata_o == $past(appl))
        else $error("applied pattern wrong");
    pwm_pin_off_a: assert property (!rt |=> !swpwm_oe_n_o)
        else $error("pwm pin released outside routing");
    enc_pulse_a: assert property (enc_arm_s |-> enc_hold_s)
        else $error("encoder pulse missing");
    hall_quiet_a: assert property (hall_s |-> !$rose(out_oe_n_o[0]))
        else $error("encoder pulse under hall feedback");
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
        const_route_a: assert property (rt && sel[c][15:9] == 7'h00 |=> pin_n[c] == $past(gate[c] & ~sel[c][8]))
            else $error("constant route level wrong");
    end
endmodule : dor_chk
bind dor_top dor_chk #(.SWPWM_HOLD(SWPWM_HOLD), .OUT_HOLD(OUT_HOLD)) dor_chk_inst (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .enc_step_i(enc_step_i),
    .pos_step_i(pos_step_i), .hall_fb_i(hall_fb_i), .out_o(out_o), .out_oe_n_o(out_oe_n_o),
    .brake_o(brake_o), .brake_oe_n_o(brake_oe_n_o), .swpwm_o(swpwm_o), .swpwm_oe_n_o(swpwm_oe_n_o));
`default_nettype wire

/* testbench.sv */
// Self-checking bench for dor_top with pull-up loads on its pins.
// Assumes dor_pkg, dor_load and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import dor_pkg::*;
    localparam int SH = 4;
    localparam int OH = 8;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic enc_step_i = 1'b0;
    logic pos_step_i = 1'b0;
    logic hall_fb_i = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    logic [NUM_OUT-1:0] out_o, out_oe_n_o;
    logic brake_o, brake_oe_n_o, swpwm_o, swpwm_oe_n_o;
    logic [5:0] pin;
    logic last = 1'b0;
    int err_total = 0;
    int n_checks = 0;
    int mon = 1;
    int rise = 0;
    int hi = 0;
    dor_top #(.SWPWM_HOLD(SH), .OUT_HOLD(OH)) dor_top_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .enc_step_i(enc_step_i), .pos_step_i(pos_step_i), .hall_fb_i(hall_fb_i), .out_o(out_o),
        .out_oe_n_o(out_oe_n_o), .brake_o(brake_o), .brake_oe_n_o(brake_oe_n_o), .swpwm_o(swpwm_o),
        .swpwm_oe_n_o(swpwm_oe_n_o));
    dor_load #(.W(6)) dor_load_inst (.drv_i({brake_o, out_o, swpwm_o}),
        .oe_n_i({brake_oe_n_o, out_oe_n_o, swpwm_oe_n_o}), .lvl_o(pin));
    initial
    begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    // Counts rises and high cycles of the watched pin
    always @(negedge clk_sys_i)
    begin
        rise += int'(pin[mon] && !last);
        hi += int'(pin[mon]);
        last = pin[mon];
    end
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(rdata_o, exp);
    endtask : rc
    task automatic settle();
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask : settle
    task automatic run_src(input logic [7:0] code, input logic hl, input int m);
        int ch;
        int k;
        int r0;
        int h0;
        logic enc;
        ch = (int'(code) - 1) % NUM_CH;
        enc = code < SRC_POS_FIRST;
        k = enc ? int'(code - SRC_ENC_FIRST) : int'(code - SRC_POS_FIRST);
        hall_fb_i <= hl;
        wr(OFS_SEL_BASE + 8'(4 * ch), {16'h0000, code, 8'(ch)});
        settle();
        mon = ch;
        repeat (2) @(negedge clk_sys_i);
        r0 = rise;
        h0 = hi;
        for (int i = 0; i < 2 * (1 << k); i++)
        begin
            @(posedge clk_sys_i);
            enc_step_i <= enc ? 1'b1 : 1'($urandom);
            pos_step_i <= enc ? 1'($urandom) : 1'b1;
            @(posedge clk_sys_i);
            enc_step_i <= 1'b0;
            pos_step_i <= 1'b0;
            repeat (9) @(posedge clk_sys_i);
        end
        chk(32'(rise - r0), 32'(m));
        chk(32'(hi - h0), 32'(m * ((ch == 0) ? SH : OH)));
    endtask : run_src
    task automatic report_and_stop();
        if (err_total == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (60000) @(posedge clk_sys_i);
        err_total++;
        report_and_stop();
    end
    // ----
    // Scenarios
    // ----
    initial
    begin
        logic [31:0] c, p, o, m, e;
        logic [15:0] s;
        int ch, g, k;
        void'($urandom(32'h7FD84763));
        repeat (12) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        for (int i = 0; i < 16; i++)
            rc(8'(4 * i), (i >= 8 && i <= 12) ? 32'h100 : (i == 13) ? 32'h7D0 : (i == 14) ? 32'h32 : 32'h0);
        chk({26'h0, pin}, 32'h0);
        wr(OFS_PWM_FREQ, 32'h7D1);
        rc(OFS_PWM_FREQ, 32'h7D0);
        wr(OFS_PWM_DUTY, 32'h01);
        rc(OFS_PWM_DUTY, 32'h32);
        wr(OFS_PWM_DUTY, 32'h65);
        rc(OFS_PWM_DUTY, 32'h32);
        wr(OFS_PWM_FREQ, 32'h3E8);
        rc(OFS_PWM_FREQ, 32'h3E8);
        wr(OFS_PWM_FREQ, 32'h7D0);
        wr(OFS_PWM_DUTY, 32'h64);
        rc(OFS_PWM_DUTY, 32'h64);
        for (int i = 0; i < 24; i++)
        begin
            c = (i == 0) ? 32'h0001_0001 : $urandom;
            p = (i < 4) ? 32'h0 : $urandom;
            o = (i < 8) ? 32'h0 : $urandom;
            m = $urandom;
            wr(OFS_CTRL_WORD, c);
            wr(OFS_POLARITY, p);
            wr(OFS_OVERRIDE, o);
            wr(OFS_MAN_VALUE, m);
            wr(OFS_APPLIED, 32'hFFFF_FFFF);
            e = ((o & m) | (~o & c)) ^ p;
            settle();
            chk({26'h0, pin}, {26'h0, e[0], e[19:16], 1'b0});
            rc(OFS_APPLIED, {12'h0, e[19:16], 15'h0, e[0]});
            rc(OFS_OVERRIDE, o);
        end
        wr(OFS_ROUTE_EN, 32'h1);
        for (int i = 0; i < 30; i++)
        begin
            ch = i % NUM_CH;
            g = $urandom_range(31, 0);
            s = {7'h00, 1'($urandom), 1'($urandom), 2'b00, 5'(g)};
            c = $urandom;
            wr(OFS_CTRL_WORD, c);
            wr(OFS_SEL_BASE + 8'(4 * ch), {16'h0, s});
            settle();
            chk({30'h0, pin[5], pin[ch]}, {30'h0, c[0], !s[8] && (c[g] ^ s[7])});
        end
        wr(OFS_CTRL_WORD, 32'h1F);
        for (int cd = 2; cd <= 15; cd++)
            run_src(8'(cd), 1'b0, 2);
        run_src(SRC_ENC_FIRST, 1'b1, 0);
        run_src(SRC_POS_FIRST, 1'b1, 2);
        hall_fb_i <= 1'b0;
        wr(OFS_PWM_DUTY, 32'h32);
        wr(OFS_CTRL_WORD, 32'h21);
        wr(OFS_SEL_BASE + 8'h04, 32'h1005);
        wr(OFS_SEL_BASE + 8'h08, 32'h1105);
        wr(OFS_SEL_BASE + 8'h0C, 32'h1086);
        settle();
        k = 0;
        g = 0;
        for (int i = 0; i < 25000; i++)
        begin
            @(negedge clk_sys_i);
            k += int'(pin[1]);
            g += int'(pin[2] === pin[1] || pin[3] !== pin[1]);
        end
        chk(32'(g), 32'h0);
        chk(32'(k > 12250 && k < 12750), 32'h1);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
